// >>> bench/sic_mac_model.sv
// upstream mac model offering request symbol pairs
`timescale 1ns/1ps
module sic_mac_model (
    input wire logic pclk,
    input wire logic req_ready,
    output logic req_valid,
    output logic [4:0] req_sym_a,
    output logic [4:0] req_sym_b,
    output logic req_parity,
    output logic req_jk
);
    initial begin
        req_valid = 1'b0;
        req_sym_a = 5'h1f;
        req_sym_b = 5'h00;
        req_parity = 1'b0;
        req_jk = 1'b0;
    end

    // parity is odd over the pair; bad flips it only on command
    task automatic send(input logic [4:0] a, input logic [4:0] b, input logic jk, input logic bad);
        req_valid <= 1'b1;
        req_sym_a <= a;
        req_sym_b <= b;
        req_jk <= jk;
        req_parity <= ~(^{a, b}) ^ bad;
        @(posedge pclk);
        while (req_ready !== 1'b1) @(posedge pclk);
    endtask

    // lines are not held once released: show the inverse of the last value
    task automatic idle;
        req_valid <= 1'b0;
        req_sym_a <= ~req_sym_a;
        req_sym_b <= ~req_sym_b;
        req_jk <= ~req_jk;
        req_parity <= ~req_parity;
    endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the symbol injection control block
`timescale 1ns/1ps
module testbench;
    import sic_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic req_valid, req_ready, req_parity, req_jk, tx_strobe, tx_enable, tx_injected;
    logic [4:0] req_sym_a, req_sym_b, tx_sym_a, tx_sym_b, sa, sb;
    logic [10:0] q[$];
    logic [10:0] p;
    logic inj, has;
    int mismatches, n_tests, cyc, last, mode, tm, thr, cnt, k, arm;
    logic [1:0] ms[5] = '{IM_ONE, IM_ONE, IM_PER, IM_PER, IM_CONT};
    int ns[5] = '{0, 3, 0, 2, 5};

    sic_inject dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .req_valid, .req_ready, .req_sym_a, .req_sym_b, .req_parity, .req_jk, .tx_strobe, .tx_sym_a,
        .tx_sym_b, .tx_enable, .tx_injected);
    sic_mac_model mac (.pclk, .req_ready, .req_valid, .req_sym_a, .req_sym_b, .req_parity, .req_jk);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // reserved top bit is random: it must read back and change nothing
    task automatic wctl(input logic [1:0] m, input logic [2:0] t, input logic pe);
        logic [7:0] v;
        v = {1'($urandom), pe, 1'b1, m, t};
        apb(1'b1, IDX_TSC, {24'h00_0000, v});
        mode = m;
        tm = t;
        apb(1'b0, IDX_TSC, 32'h0000_0000);
        chk(rd, {24'h00_0000, v});
    endtask

    task automatic strb;
        @(posedge pclk);
        while (tx_strobe !== 1'b1) @(posedge pclk);
    endtask

    // pairs are sent just after a strobe so none lands between tick and strobe
    task automatic feed(input logic jk, input logic bad);
        strb;
        mac.send(5'($urandom), 5'($urandom), jk, bad);
        mac.idle;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 10000) begin
            mismatches++;
            complete_run;
        end
        if (presetn && tx_strobe === 1'b1) begin
            if (last > 0) chk(cyc - last, 20);
            last = cyc;
            has = q.size() > 0;
            p = has ? q.pop_front() : 11'h000;
            inj = 1'b0;
            if (mode == IM_CONT) inj = has;
            if (mode == IM_PER) begin
                inj = cnt == 0;
                cnt = inj ? thr : cnt - 1;
            end
            if (mode == IM_ONE && has) begin
                if (arm) k--;
                if (!arm && p[10]) begin
                    arm = 1;
                    k = thr;
                end
                if (arm && k == 0) begin
                    inj = 1'b1;
                    mode = IM_NONE;
                end
            end
            if (inj) chk({tx_injected, tx_sym_a, tx_sym_b}, {1'b1, sa, sb});
            else if (tm == TM_ACTIVE && (has || mode == IM_NONE))
                chk({tx_injected, tx_sym_a, tx_sym_b}, {1'b0, has ? p[9:0] : {SYM_IDLE, SYM_IDLE}});
        end
        if (req_valid === 1'b1 && req_ready === 1'b1) q.push_back({req_jk, req_sym_a, req_sym_b});
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mode = IM_NONE;
        tm = TM_OFF;
        void'($urandom(7414));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(tx_enable, 1'b0);
        apb(1'b0, IDX_TSC, 32'h0000_0000);
        chk(rd, 32'h0000_00a2);
        apb(1'b0, IDX_STS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 4'hf, 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h8000_0000);
        sa = 5'($urandom);
        sb = 5'($urandom);
        apb(1'b1, IDX_ISA, {27'h000_0000, sa});
        apb(1'b1, IDX_ISB, {27'h000_0000, sb});
        apb(1'b0, IDX_ISB, 32'h0000_0000);
        chk(rd, {27'h000_0000, sb});
        strb;
        wctl(IM_NONE, TM_ACTIVE, 1'b0);
        // fill the buffer until it refuses, then let it drain
        strb;
        for (int i = 0; i < 9; i++) begin
            mac.send(5'($urandom), 5'($urandom), 1'($urandom), 1'b0);
        end
        mac.idle;
        // the ninth pair took the slot freed by one drain, so the buffer is full again
        @(posedge pclk);
        chk(req_ready, 1'b0);
        chk(tx_enable, 1'b1);
        while (q.size() > 0) strb;
        // request parity counts only while enabled
        for (int i = 0; i < 2; i++) begin
            strb;
            wctl(IM_NONE, TM_ACTIVE, i[0]);
            feed(1'b0, 1'b1);
            repeat (3) @(posedge pclk);
            apb(1'b0, IDX_STS, 32'h0000_0000);
            chk(rd[0], i[0]);
        end
        apb(1'b1, IDX_STS, 32'h0000_0001);
        apb(1'b0, IDX_STS, 32'h0000_0000);
        chk(rd[0], 1'b0);
        // injection modes; continuous also runs over the idle transmit mode
        for (int i = 0; i < 5; i++) begin
            strb;
            // let the model finish this strobe before its counter is reloaded
            @(posedge pclk);
            thr = ns[i];
            cnt = thr;
            arm = 0;
            apb(1'b1, IDX_THR, 32'(thr));
            apb(1'b0, IDX_STS, 32'h0000_0000);
            chk(rd[15:8], thr[7:0]);
            wctl(ms[i], (ms[i] == IM_CONT) ? TM_IDLE : TM_ACTIVE, 1'b0);
            mac.send(5'($urandom), 5'($urandom), 1'b0, 1'b0);
            mac.idle;
            for (int j = 0; j < 8; j++) feed(j == 1, 1'b0);
            if (ms[i] == IM_ONE) begin
                apb(1'b0, IDX_TSC, 32'h0000_0000);
                chk(rd[6:0], {2'b01, IM_NONE, TM_ACTIVE});
            end
        end
        wctl(IM_NONE, TM_ACTIVE, 1'b0);
        strb;
        strb;
        complete_run;
    end
endmodule

// >>> logic/sic_fifo.sv
// shift-register fifo; head word always comes out of a register
`timescale 1ns/1ps
module sic_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] buf_ff [D];
    logic [$clog2(D+1)-1:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != ($clog2(D+1))'(D));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = buf_ff[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + ($clog2(D+1))'(push) - ($clog2(D+1))'(pop);
        end
    end

    // a word is written to the slot it will occupy after any shift
    always_ff @(posedge pclk) begin
        for (int i = 0; i < D; i++) begin
            if (push && (32'(cnt_ff) - 32'(pop)) == i) begin
                buf_ff[i] <= in_data;
            end else if (pop && i < D - 1) begin
                buf_ff[i] <= buf_ff[i+1];
            end
        end
    end
endmodule

// >>> logic/sic_inject.sv
// transmit path symbol-pair injection control with apb registers
//
// Behaviour
// - two control bits pick none, one-shot, periodic or continuous injection.
// - injected symbols override smoother, repeat filter, encoder and transmit modes.
// - with no injection, request symbols pass through unchanged in the active transmit mode.
// - one-shot replaces the pair n pairs after the next JK.
// - one-shot with count zero replaces the JK pair itself.
// - after one-shot, low control bit clears alone; nothing else clears.
// - periodic replaces every (n+1)th symbol pair.
// - periodic with count zero replaces every data pair.
// - continuous replaces every outgoing pair whatever the count.
// - request parity is checked only while the parity enable bit is set.
// - reserved top control bit resets to one, writes have no effect; here a write stores the bit and it reads back.
// - eight-bit down counter steps once per 80 ns pair period.
// - counter reloads from threshold at zero and on threshold writes.
// - counter runs only in one-shot or periodic, reset to zero.
// - reset enables the smoother and selects the off transmit mode.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sic_inject
    import sic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [sic_pkg::SYM_W-1:0] req_sym_a,
    input wire logic [sic_pkg::SYM_W-1:0] req_sym_b,
    input wire logic req_parity,
    input wire logic req_jk,
    output logic tx_strobe,
    output logic [sic_pkg::SYM_W-1:0] tx_sym_a,
    output logic [sic_pkg::SYM_W-1:0] tx_sym_b,
    output logic tx_enable,
    output logic tx_injected
);
    import sic_pkg::*;

    ////////////////////////////////////////////////////////////////
    // registers and bus decode
    logic [7:0] tsc_ff;
    logic [7:0] thr_ff;
    logic [4:0] isa_ff;
    logic [4:0] isb_ff;
    logic perr_ff;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    sic_os_t os_ff;
    logic acc;
    logic wr;
    logic [3:0] idx;
    logic hit;
    logic wr_tsc;
    logic wr_thr;
    logic [1:0] imode;
    logic [2:0] tmode;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign idx = paddr[5:2];
    assign hit = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00)
                 && (idx >= IDX_TSC) && (idx <= IDX_STS);
    assign wr_tsc = wr && hit && (idx == IDX_TSC);
    assign wr_thr = wr && hit && (idx == IDX_THR);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign imode = {tsc_ff[IC_HI], tsc_ff[IC_LO]};
    assign tmode = tsc_ff[TM_LSB+2:TM_LSB];

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && hit) begin
            unique case (idx)
                IDX_TSC: prdata = {24'h00_0000, tsc_ff};
                IDX_THR: prdata = {24'h00_0000, thr_ff};
                IDX_ISA: prdata = {27'h000_0000, isa_ff};
                IDX_ISB: prdata = {27'h000_0000, isb_ff};
                default: prdata = {16'h0000, cnt_ff, 6'h00, os_ff == SIC_OS_COUNT, perr_ff};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // pair pacing and request fifo
    logic tick;
    logic f_valid;
    logic [FW-1:0] f_data;
    logic pop;
    logic d_jk;
    logic [4:0] d_a;
    logic [4:0] d_b;

    sic_pace #(
        .DIV(PAIR_CYC)
    ) u_pace (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // the fifo drains one pair per period, so a fast source is stalled
    sic_fifo #(
        .W(FW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_jk, req_parity, req_sym_a, req_sym_b}),
        .out_valid(f_valid),
        .out_ready(tick),
        .out_data(f_data)
    );

    assign pop = tick && f_valid;
    assign d_jk = f_valid && f_data[FW-1];
    // an empty fifo shows idle, never a stale word
    assign d_a = f_valid ? f_data[2*SYM_W-1:SYM_W] : SYM_IDLE;
    assign d_b = f_valid ? f_data[SYM_W-1:0] : SYM_IDLE;

    function automatic logic odd_ok(input logic [FW-2:0] w);
        odd_ok = ^w;
    endfunction

    ////////////////////////////////////////////////////////////////
    // injection decision
    logic inj_now;
    logic os_fire;

    always_comb begin
        os_fire = 1'b0;
        if (imode == IM_ONE) begin
            if (os_ff == SIC_OS_COUNT) begin
                // a threshold rewritten to zero mid-count fires at once instead of wrapping
                os_fire = (cnt_ff <= 8'h01);
            end else begin
                os_fire = d_jk && (thr_ff == 8'h00);
            end
        end
    end

    always_comb begin
        unique case (imode)
            IM_NONE: inj_now = 1'b0;
            IM_ONE: inj_now = os_fire;
            IM_PER: inj_now = (cnt_ff == 8'h00);
            IM_CONT: inj_now = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // one-shot sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_ff <= SIC_OS_WAIT;
        end else if (imode != IM_ONE) begin
            os_ff <= SIC_OS_WAIT;
        end else if (tick) begin
            unique case (os_ff)
                SIC_OS_WAIT: begin
                    if (d_jk && thr_ff != 8'h00) begin
                        os_ff <= SIC_OS_COUNT;
                    end
                end
                SIC_OS_COUNT: begin
                    if (os_fire) begin
                        os_ff <= SIC_OS_WAIT;
                    end
                end
                default: os_ff <= SIC_OS_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // injection counter
    always_comb begin
        nxt_cnt = cnt_ff;
        if (imode == IM_PER) begin
            nxt_cnt = (cnt_ff == 8'h00) ? thr_ff : cnt_ff - 8'h01;
        end else if (imode == IM_ONE) begin
            if (os_ff == SIC_OS_WAIT) begin
                nxt_cnt = d_jk ? thr_ff : cnt_ff;
            end else begin
                nxt_cnt = os_fire ? thr_ff : cnt_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
        end else if (wr_thr) begin
            cnt_ff <= pwdata[7:0];
        end else if (tick) begin
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsc_ff <= TSC_RST;
        end else if (wr_tsc) begin
            // a write wins over the self-clear so a new request is not lost
            tsc_ff <= pwdata[7:0];
        end else if (tick && imode == IM_ONE && os_fire) begin
            tsc_ff[IC_LO] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_ff <= THR_RST;
            isa_ff <= SYM_RST;
            isb_ff <= SYM_RST;
        end else if (wr && hit) begin
            if (idx == IDX_THR) begin
                thr_ff <= pwdata[7:0];
            end
            if (idx == IDX_ISA) begin
                isa_ff <= pwdata[4:0];
            end
            if (idx == IDX_ISB) begin
                isb_ff <= pwdata[4:0];
            end
        end
    end

    // parity error: sticky, write one to clear, a new error wins
    logic perr_set;
    assign perr_set = req_valid && req_ready && tsc_ff[PAR_BIT]
                      && !odd_ok({req_parity, req_sym_a, req_sym_b});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perr_ff <= 1'b0;
        end else if (perr_set) begin
            perr_ff <= 1'b1;
        end else if (wr && hit && idx == IDX_STS && pwdata[STS_PERR]) begin
            perr_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmit output
    logic [4:0] tm_a;
    logic [4:0] tm_b;

    // smoother itself sits upstream; its enable bit is only stored here
    always_comb begin
        tm_a = SYM_QUIET;
        tm_b = SYM_QUIET;
        unique case (tmode)
            TM_ACTIVE: begin
                tm_a = d_a;
                tm_b = d_b;
            end
            TM_IDLE: begin
                tm_a = SYM_IDLE;
                tm_b = SYM_IDLE;
            end
            TM_MASTER: tm_a = SYM_HALT;
            TM_HALT: begin
                tm_a = SYM_HALT;
                tm_b = SYM_HALT;
            end
            default: begin
                tm_a = SYM_QUIET;
                tm_b = SYM_QUIET;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sym_a <= SYM_QUIET;
            tx_sym_b <= SYM_QUIET;
            tx_injected <= 1'b0;
            tx_strobe <= 1'b0;
        end else begin
            tx_strobe <= tick;
            if (tick) begin
                tx_sym_a <= inj_now ? isa_ff : tm_a;
                tx_sym_b <= inj_now ? isb_ff : tm_b;
                tx_injected <= inj_now;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable <= 1'b0;
        end else begin
            tx_enable <= (tmode != TM_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pass;
        tick && imode == IM_NONE && tmode == TM_ACTIVE && f_valid |=> tx_sym_a == $past(f_data[9:5])
            && tx_sym_b == $past(f_data[4:0]) && !tx_injected;
    endproperty
    a_pass: assert property (p_pass) else $error("pass-through altered");

    property p_prio;
        tick && imode == IM_CONT |=> tx_injected && tx_sym_a == $past(isa_ff) && tx_sym_b == $past(isb_ff);
    endproperty
    a_prio: assert property (p_prio) else $error("continuous pair not injected");

    property p_per0;
        // mode and threshold are looked at again at the second tick, software may move them between
        tick && imode == IM_PER && thr_ff == 8'h00 && cnt_ff == 8'h00 && !wr_thr
            ##20 tick && imode == IM_PER && thr_ff == 8'h00 |=> tx_injected;
    endproperty
    a_per0: assert property (p_per0) else $error("periodic zero missed");

    property p_osclr;
        tick && imode == IM_ONE && os_fire && !wr_tsc |=> !tsc_ff[IC_LO] && tsc_ff[IC_HI] == $past(tsc_ff[IC_HI])
            && tsc_ff[7:5] == $past(tsc_ff[7:5]);
    endproperty
    a_osclr: assert property (p_osclr) else $error("one-shot clear wrong");

    property p_jk0;
        tick && imode == IM_ONE && os_ff == SIC_OS_WAIT && d_jk && thr_ff == 8'h_00 |=> tx_injected;
    endproperty
    a_jk0: assert property (p_jk0) else $error("jk pair not replaced");

    property p_reload;
        wr_thr |=> cnt_ff == $past(pwdata[7:0]);
    endproperty
    a_reload: assert property (p_reload) else $error("threshold write no reload");

    property p_hold;
        (imode == IM_NONE || imode == IM_CONT) && !wr_thr |=> $stable(cnt_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("counter ran in wrong mode");

    property p_nopar;
        !tsc_ff[PAR_BIT] && !perr_ff |=> !perr_ff;
    endproperty
    a_nopar: assert property (p_nopar) else $error("parity flagged while off");

    property p_rate;
        tick |=> !tick [*8] ##1 !tick [*8] ##1 !tick [*3] ##1 tick;
    endproperty
    a_rate: assert property (p_rate) else $error("pair period wrong");

    c_oneshot: cover property (tick && imode == IM_ONE && os_fire);
    c_periodic: cover property (tick && imode == IM_PER && inj_now && thr_ff != 8'h_00);
    c_full: cover property (req_valid && !req_ready);
endmodule

// >>> logic/sic_pace.sv
// divider giving one enable pulse per symbol-pair period
`timescale 1ns/1ps
module sic_pace #(
    parameter int DIV = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [7:0] cnt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff == 8'(DIV - 1)) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign tick = (cnt_ff == 8'(DIV - 1));
endmodule

// >>> logic/sic_pkg.sv
// constants shared by the symbol injection control block
package sic_pkg;
    localparam int CLK_NS = 4;
    localparam int PAIR_NS = 80;
    localparam int PAIR_CYC = (PAIR_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYM_W = 5;
    localparam int CNT_W = 8;
    localparam int FIFO_DEPTH = 8;
    // fifo word: {jk, parity, sym_a, sym_b}
    localparam int FW = 2 * SYM_W + 2;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_TSC = 4'h4;
    localparam logic [3:0] IDX_THR = 4'h5;
    localparam logic [3:0] IDX_ISA = 4'h6;
    localparam logic [3:0] IDX_ISB = 4'h7;
    localparam logic [3:0] IDX_STS = 4'h8;
    // transmit_state_control fields
    localparam int TM_LSB = 0;
    localparam int IC_LO = 3;
    localparam int IC_HI = 4;
    localparam int SMO_BIT = 5;
    localparam int PAR_BIT = 6;
    localparam int RES_BIT = 7;
    localparam logic [7:0] TSC_RST = 8'ha2;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam logic [4:0] SYM_RST = 5'h00;
    // status fields
    localparam int STS_PERR = 0;
    localparam int STS_ARM = 1;
    localparam int STS_CNT = 8;
    // injection modes, upper bit first
    localparam logic [1:0] IM_NONE = 2'b00;
    localparam logic [1:0] IM_ONE = 2'b01;
    localparam logic [1:0] IM_PER = 2'b10;
    localparam logic [1:0] IM_CONT = 2'b11;
    // transmit modes
    localparam logic [2:0] TM_ACTIVE = 3'b000;
    localparam logic [2:0] TM_IDLE = 3'b001;
    localparam logic [2:0] TM_OFF = 3'b010;
    localparam logic [2:0] TM_MASTER = 3'b100;
    localparam logic [2:0] TM_HALT = 3'b101;
    localparam logic [4:0] SYM_IDLE = 5'h1f;
    localparam logic [4:0] SYM_QUIET = 5'h00;
    localparam logic [4:0] SYM_HALT = 5'h04;
    typedef enum logic [1:0] {
        SIC_OS_WAIT = 2'b01,
        SIC_OS_COUNT = 2'b10
    } sic_os_t;
endpackage
